// file: quad_uart_consts.svh
`ifndef QUAD_UART_CONSTS_SVH
`define QUAD_UART_CONSTS_SVH
`define CMD_MEM_RD 4'h6
`define CMD_MEM_WR 4'h7
`define OFF_GLOBAL 8
`define REG_DATA 4'h0
`define REG_IER 4'h1
`define REG_FEATURE_CONTROL_REG 4'h2
`define REG_MCR 4'h3
`define REG_MSR 4'h4
`define REG_DIV 4'h5
`define REG_TRIG 4'h6
`define REG_LVL 4'h7
`define REG_TADLY 4'h8
`define GREG_INT 4'h0
`define GREG_TMR_RLD 4'h1
`define GREG_TMR_CTL 4'h2
`define FC_PRESC 3
`define FC_IR_INV 4
`define FC_IR_MODE 5
`define FC_OS8 6
`define DIV_RESET 16'h0001
`define TRIG_RX_RESET 7'h01
`define TRIG_TX_RESET 7'h00
`define OS16_LAST 4'hF
`define OS8_LAST 4'h7
`define OS16_MID 4'h7
`define OS8_MID 4'h3
`define IR16_PULSE 4'h3
`define IR8_PULSE 4'h1
`define FRAME_LAST 4'h9
`define PRESC_LAST 2'h3
`define FIFO_DEPTH 64
`define ADDR_STEP 12'h004
`endif

// file: quad_uart_pkg.sv
package quad_uart_pkg;
  typedef enum logic [3:0] {
    T_IDLE = 4'h1,
    T_WAIT = 4'h2,
    T_XFER = 4'h4,
    T_TURN = 4'h8
  } tgt_state_t;

  typedef struct packed {
    tgt_state_t st;
    logic frame_q;
    logic wr;
    logic [11:0] addr;
    logic [31:0] ad_out;
    logic par;
    logic par_oe;
    logic [15:0] tmr_rld;
    logic [15:0] tmr_cnt;
    logic tmr_en;
    logic tmr_int;
  } tgt_t;

  typedef struct packed {
    logic [7:0] feature_control_reg;
    logic [1:0] ier;
    logic [1:0] mcr;
    logic [15:0] div;
    logic [6:0] rx_trig;
    logic [6:0] tx_trig;
    logic [3:0] tadly;
    logic [1:0] presc;
    logic [15:0] bcnt;
    logic tx_busy;
    logic [9:0] tx_sh;
    logic [3:0] tx_bit;
    logic [3:0] tx_os;
    logic [3:0] dly;
    logic tx_line;
    logic dir;
    logic rx_busy;
    logic [7:0] rx_sh;
    logic [3:0] rx_bit;
    logic [3:0] rx_os;
    logic ir_hold;
    logic rx_push;
    logic ovr;
  } chan_t;
endpackage

// file: byte_fifo.sv
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [LW-1:0] cnt;
  } fifo_state_t;
  fifo_state_t q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready = q.cnt != LW'(DEPTH);
  assign out_valid = q.cnt != '0;
  assign out_data = mem[q.rp];
  assign level = q.cnt;
  assign push = in_valid & in_ready;
  assign pop = out_ready & out_valid;

  always_comb begin
    d = q;
    if (push) begin
      d.wp = AW'(q.wp + 1'b1);
    end
    if (pop) begin
      d.rp = AW'(q.rp + 1'b1);
    end
    d.cnt = LW'(q.cnt + LW'(push) - LW'(pop));
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[q.wp] <= in_data;
    end
  end
endmodule // byte_fifo

// file: quad_uart_pci.sv
`include "quad_uart_consts.svh"
module quad_uart_pci #(
  parameter logic [31:0] MEM_BASE = 32'hF000_0000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [31:0] ad_in,
  output logic [31:0] ad_out,
  output logic ad_oe,
  input wire logic [3:0] cbe_n,
  input wire logic frame_n,
  input wire logic irdy_n,
  output logic trdy_n,
  output logic devsel_n,
  output logic stop_n,
  output logic target_oe,
  output logic par_out,
  output logic par_oe,
  output logic perr_n,
  output logic serr_n_out,
  output logic serr_n_oe,
  output logic inta_n_out,
  output logic inta_n_oe,
  output logic [3:0] serial_out,
  input wire logic [3:0] serial_in,
  output logic [3:0] request_send_n,
  output logic [3:0] terminal_ready_n,
  input wire logic [3:0] clear_send_n,
  input wire logic [3:0] set_ready_n,
  input wire logic [3:0] carrier_detect_n,
  input wire logic [3:0] ring_indicate_n,
  output logic [3:0] dir_out
);
  localparam int LW = $clog2(`FIFO_DEPTH+1);
  quad_uart_pkg::tgt_t q, d;
  logic [31:0] chan_rd [4];
  logic [3:0] chan_int, tx_room;
  logic [3:0] treg;
  logic [1:0] chs;
  logic gsel, hit, ok, xfer, wr_go, rd_go, tmr_clr;
  logic [31:0] rd_word;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be_n);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (!be_n[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign treg = q.addr[5:2];
  assign chs = q.addr[7:6];
  assign gsel = q.addr[`OFF_GLOBAL];
  assign hit = ad_in[31:12] == MEM_BASE[31:12];
  assign ok = !(q.wr && !gsel && treg == `REG_DATA && !tx_room[chs]);
  assign xfer = q.st == quad_uart_pkg::T_XFER && !irdy_n && ok;
  assign wr_go = xfer && q.wr;
  assign rd_go = xfer && !q.wr;
  assign tmr_clr = wr_go && gsel && treg == `GREG_TMR_CTL && !cbe_n[0] && ad_in[1];

  always_comb begin
    rd_word = chan_rd[chs];
    if (gsel) begin
      unique case (treg)
        `GREG_INT: rd_word = {27'h0000000, q.tmr_int, chan_int};
        `GREG_TMR_RLD: rd_word = {16'h0000, q.tmr_rld};
        `GREG_TMR_CTL: rd_word = {q.tmr_cnt, 14'h0000, q.tmr_int, q.tmr_en};
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    logic [31:0] wd;
    wd = be_merge(rd_word, ad_in, cbe_n);
    d = q;
    d.frame_q = frame_n;
    unique case (q.st)
      quad_uart_pkg::T_IDLE: begin
        if (q.frame_q && !frame_n && hit && (cbe_n == `CMD_MEM_RD || cbe_n == `CMD_MEM_WR)) begin
          d.wr = cbe_n == `CMD_MEM_WR;
          d.addr = ad_in[11:0];
          d.st = quad_uart_pkg::T_WAIT;
        end
      end
      quad_uart_pkg::T_WAIT: begin
        d.ad_out = rd_word;
        d.st = quad_uart_pkg::T_XFER;
      end
      quad_uart_pkg::T_XFER: begin
        if (xfer) begin
          d.addr = q.addr + `ADDR_STEP;
          d.st = frame_n ? quad_uart_pkg::T_TURN : quad_uart_pkg::T_WAIT;
        end else if (!ok && frame_n) begin
          d.st = quad_uart_pkg::T_TURN;
        end
      end
      quad_uart_pkg::T_TURN: d.st = quad_uart_pkg::T_IDLE;
    endcase
    d.par = ^{q.ad_out, cbe_n};
    d.par_oe = ad_oe;
    if (wr_go && gsel && treg == `GREG_TMR_RLD) begin
      d.tmr_rld = wd[15:0];
    end
    if (wr_go && gsel && treg == `GREG_TMR_CTL) begin
      d.tmr_en = wd[0];
    end
    d.tmr_int = q.tmr_int && !tmr_clr;
    if (q.tmr_en) begin
      if (q.tmr_cnt == 16'h0000) begin
        d.tmr_cnt = q.tmr_rld;
        d.tmr_int = 1'b1;
      end else begin
        d.tmr_cnt = q.tmr_cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: quad_uart_pkg::T_IDLE, frame_q: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign ad_out = q.ad_out;
  assign ad_oe = (q.st == quad_uart_pkg::T_WAIT || q.st == quad_uart_pkg::T_XFER) && !q.wr;
  assign par_out = q.par;
  assign par_oe = q.par_oe;
  assign target_oe = q.st != quad_uart_pkg::T_IDLE;
  assign devsel_n = !(q.st == quad_uart_pkg::T_WAIT || q.st == quad_uart_pkg::T_XFER);
  assign trdy_n = !(q.st == quad_uart_pkg::T_XFER && ok);
  assign stop_n = !(q.st == quad_uart_pkg::T_XFER && !ok);
  assign perr_n = 1'b1;
  assign serr_n_out = 1'b0;
  assign serr_n_oe = 1'b0;
  assign inta_n_out = 1'b0;
  assign inta_n_oe = |{q.tmr_int, chan_int};

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  claim_on_read_a: assert property (
      q.st == quad_uart_pkg::T_IDLE && q.frame_q && !frame_n && hit
      && cbe_n == `CMD_MEM_RD |=> !devsel_n ##1 !devsel_n) else $error("read not claimed");
  parity_even_a: assert property (
      par_oe |-> par_out == ^{$past(ad_out), $past(cbe_n)}) else $error("bad read parity");
  ready_needs_sel_a: assert property (
      !trdy_n || !stop_n |-> !devsel_n && target_oe) else $error("ready without select");
  irq_open_drain_a: assert property (
      inta_n_out == 1'b0 && (inta_n_oe == |{q.tmr_int, chan_int}))
      else $error("interrupt pin misdriven");
  err_quiet_a: assert property (perr_n && !serr_n_oe) else $error("error pins active");
  timer_wrap_a: assert property (
      q.tmr_en && q.tmr_cnt == 16'h0000 |=> q.tmr_int && q.tmr_cnt == $past(q.tmr_rld))
      else $error("timer reload failed");

  for (genvar g = 0; g < 4; g++) begin : ch
    quad_uart_pkg::chan_t c_q, c_d;
    logic sel, tx_ov, tx_take, rx_ov, rx_rdy, tick, raw, s, txq_room;
    logic [7:0] tx_data, rx_data;
    logic [LW-1:0] tx_lvl, rx_lvl;
    logic [3:0] os_last, os_mid, ir_pulse;

    assign sel = !gsel && chs == 2'(g);
    assign tx_take = !c_q.tx_busy && tx_ov;
    assign os_last = c_q.feature_control_reg[`FC_OS8] ? `OS8_LAST : `OS16_LAST;
    assign os_mid = c_q.feature_control_reg[`FC_OS8] ? `OS8_MID : `OS16_MID;
    assign ir_pulse = c_q.feature_control_reg[`FC_OS8] ? `IR8_PULSE : `IR16_PULSE;
    assign tick = (!c_q.feature_control_reg[`FC_PRESC] || c_q.presc == `PRESC_LAST) && c_q.bcnt == 16'h0000;
    assign raw = serial_in[g] ^ (c_q.feature_control_reg[`FC_IR_MODE] && c_q.feature_control_reg[`FC_IR_INV]);
    assign s = c_q.feature_control_reg[`FC_IR_MODE] ? !(c_q.ir_hold || raw) : raw;
    assign tx_room[g] = txq_room;

    byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) txq (
      .clock(clock), .rst_n(rst_n),
      .in_valid(wr_go && sel && treg == `REG_DATA && !cbe_n[0]), .in_ready(txq_room),
      .in_data(ad_in[7:0]), .out_valid(tx_ov), .out_ready(tx_take), .out_data(tx_data),
      .level(tx_lvl));
    byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) rxq (
      .clock(clock), .rst_n(rst_n),
      .in_valid(c_q.rx_push), .in_ready(rx_rdy), .in_data(c_q.rx_sh),
      .out_valid(rx_ov), .out_ready(rd_go && sel && treg == `REG_DATA && !cbe_n[0]),
      .out_data(rx_data), .level(rx_lvl));

    always_comb begin
      unique case (treg)
        `REG_DATA: chan_rd[g] = {24'h000000, rx_ov ? rx_data : 8'h00};
        `REG_IER: chan_rd[g] = {30'h00000000, c_q.ier};
        `REG_FEATURE_CONTROL_REG: chan_rd[g] = {24'h000000, c_q.feature_control_reg};
        `REG_MCR: chan_rd[g] = {30'h00000000, c_q.mcr};
        `REG_MSR: chan_rd[g] = {28'h0000000, ~ring_indicate_n[g], ~carrier_detect_n[g],
                                ~set_ready_n[g], ~clear_send_n[g]};
        `REG_DIV: chan_rd[g] = {16'h0000, c_q.div};
        `REG_TRIG: chan_rd[g] = {17'h00000, c_q.tx_trig, 1'b0, c_q.rx_trig};
        `REG_LVL: chan_rd[g] = {17'h00000, tx_lvl, c_q.ovr, rx_lvl};
        `REG_TADLY: chan_rd[g] = {28'h0000000, c_q.tadly};
        default: chan_rd[g] = 32'h0000_0000;
      endcase
    end

    assign chan_int[g] = (c_q.ier[0] && rx_lvl != '0 && rx_lvl >= c_q.rx_trig)
                      || (c_q.ier[1] && tx_lvl <= c_q.tx_trig);

    always_comb begin
      logic [31:0] wd;
      wd = be_merge(chan_rd[g], ad_in, cbe_n);
      c_d = c_q;
      c_d.rx_push = 1'b0;
      if (wr_go && sel) begin
        unique case (treg)
          `REG_IER: c_d.ier = wd[1:0];
          `REG_FEATURE_CONTROL_REG: c_d.feature_control_reg = wd[7:0];
          `REG_MCR: c_d.mcr = wd[1:0];
          `REG_DIV: c_d.div = wd[15:0];
          `REG_TRIG: begin
            c_d.rx_trig = wd[6:0];
            c_d.tx_trig = wd[14:8];
          end
          `REG_TADLY: c_d.tadly = wd[3:0];
          default: c_d.ier = c_q.ier;
        endcase
      end
      c_d.presc = c_q.feature_control_reg[`FC_PRESC] ? 2'(c_q.presc + 2'h1) : 2'h0;
      if (!c_q.feature_control_reg[`FC_PRESC] || c_q.presc == `PRESC_LAST) begin
        c_d.bcnt = c_q.bcnt == 16'h0000 ? c_q.div : c_q.bcnt - 16'h0001;
      end
      if (tx_take) begin
        c_d.tx_busy = 1'b1;
        c_d.tx_sh = {1'b1, tx_data, 1'b0};
        c_d.tx_bit = 4'h0;
        c_d.tx_os = 4'h0;
      end else if (tick && (c_q.tx_busy || c_q.dly != 4'h0)) begin
        c_d.tx_os = c_q.tx_os == os_last ? 4'h0 : c_q.tx_os + 4'h1;
        if (c_q.tx_os == os_last && c_q.tx_busy) begin
          c_d.tx_sh = {1'b1, c_q.tx_sh[9:1]};
          c_d.tx_bit = c_q.tx_bit + 4'h1;
          if (c_q.tx_bit == `FRAME_LAST) begin
            c_d.tx_busy = 1'b0;
            c_d.dly = c_q.tadly;
          end
        end else if (c_q.tx_os == os_last) begin
          c_d.dly = c_q.dly - 4'h1;
        end
      end
      if (c_d.feature_control_reg[`FC_IR_MODE]) begin
        c_d.tx_line = c_d.tx_busy && !c_d.tx_sh[0] && c_d.tx_os < ir_pulse;
      end else begin
        c_d.tx_line = !c_d.tx_busy || c_d.tx_sh[0];
      end
      c_d.dir = c_d.tx_busy || c_d.dly != 4'h0;
      c_d.ir_hold = c_q.feature_control_reg[`FC_IR_MODE] && (c_q.ir_hold || raw);
      if (!c_q.rx_busy) begin
        if (!s) begin
          c_d.rx_busy = 1'b1;
          c_d.rx_os = 4'h0;
          c_d.rx_bit = 4'h0;
        end
      end else if (tick) begin
        c_d.rx_os = c_q.rx_os == os_last ? 4'h0 : c_q.rx_os + 4'h1;
        if (c_q.rx_os == os_mid) begin
          c_d.ir_hold = 1'b0;
          c_d.rx_bit = c_q.rx_bit + 4'h1;
          if (c_q.rx_bit == 4'h0) begin
            c_d.rx_busy = !s;
          end else if (c_q.rx_bit == `FRAME_LAST) begin
            c_d.rx_busy = 1'b0;
            c_d.rx_push = s;
          end else begin
            c_d.rx_sh = {s, c_q.rx_sh[7:1]};
          end
        end
      end
      c_d.ovr = (c_q.ovr && !(rd_go && sel && treg == `REG_LVL)) || (c_q.rx_push && !rx_rdy);
    end

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        c_q <= '{div: `DIV_RESET, rx_trig: `TRIG_RX_RESET, tx_trig: `TRIG_TX_RESET,
                 tx_line: 1'b1, default: '0};
      end else begin
        c_q <= c_d;
      end
    end

    assign serial_out[g] = c_q.tx_line;
    assign dir_out[g] = c_q.dir;
    assign request_send_n[g] = !c_q.mcr[1];
    assign terminal_ready_n[g] = !c_q.mcr[0];

    tx_idle_high_a: assert property (
        !c_q.tx_busy && !c_q.feature_control_reg[`FC_IR_MODE] |-> serial_out[g])
      else $error("transmit not idle high");
    dir_hold_a: assert property (
        $fell(c_q.tx_busy) && c_q.tadly != 4'h0 |-> dir_out[g])
      else $error("direction dropped early");
    modem_out_a: assert property (
        request_send_n[g] == !c_q.mcr[1] && terminal_ready_n[g] == !c_q.mcr[0])
      else $error("modem output mismatch");
    byte_lane_a: assert property (
        wr_go && sel && treg == `REG_MCR && cbe_n[0] |=> c_q.mcr == $past(c_q.mcr))
      else $error("disabled lane written");
  end
endmodule // quad_uart_pci

// file: pci_host_model.sv
`include "quad_uart_consts.svh"
module pci_host_model #(
  parameter logic [31:0] BASE = 32'hF000_0000
) (
  input wire logic clock,
  output logic frame_n,
  output logic irdy_n,
  output logic [3:0] cbe_n,
  output logic [31:0] host_ad,
  input wire logic [31:0] ad_bus,
  input wire logic trdy_n,
  input wire logic stop_n,
  input wire logic par_out,
  input wire logic par_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    frame_n = 1'b1;
    irdy_n = 1'b1;
    cbe_n = 4'hF;
    host_ad = 32'h0000_0000;
  end
  // One data phase; res 0 taken, 1 retry, 2 no claim
  task automatic access(input logic [3:0] cmd, input logic [11:0] off,
      input logic [31:0] wdata, input logic [3:0] be_n, output logic [31:0] rdata,
      output logic [1:0] res, output logic par_ok);
    int n;
    res = 2'h2;
    rdata = 32'h0000_0000;
    par_ok = 1'b0;
    @(negedge clock);
    frame_n = 1'b0;
    cbe_n = cmd;
    host_ad = {BASE[31:12], off};
    @(negedge clock);
    frame_n = 1'b1;
    irdy_n = 1'b0;
    cbe_n = be_n;
    host_ad = (cmd == `CMD_MEM_WR) ? wdata : ~host_ad;
    for (n = 0; n < 8 && res == 2'h2; n++) begin
      @(posedge clock);
      if (trdy_n === 1'b0) begin
        res = 2'h0;
        rdata = ad_bus;
      end else if (stop_n === 1'b0) begin
        res = 2'h1;
      end
    end
    @(negedge clock);
    irdy_n = 1'b1;
    cbe_n = 4'hF;
    host_ad = ~host_ad;
    @(posedge clock);
    par_ok = par_oe === 1'b1 && par_out === ^{rdata, be_n};
  endtask
endmodule // pci_host_model

// file: quad_pci_uart_pin_interface_test.sv
`include "quad_uart_consts.svh"
module quad_pci_uart_pin_interface_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, frame_n, irdy_n, ad_oe, trdy_n, devsel_n, stop_n, target_oe;
  logic par_out, par_oe, perr_n, serr_n_out, serr_n_oe, inta_n_out, inta_n_oe, inta_line;
  logic [3:0] cbe_n, serial_out, request_send_n, terminal_ready_n, dir_out;
  logic [3:0] clear_send_n, set_ready_n, carrier_detect_n, ring_indicate_n;
  logic [31:0] host_ad, ad_out, ad_bus, rdata;
  logic [1:0] res;
  logic pok;
  int bad_count, n_checks, cycles;
  assign ad_bus = ad_oe ? ad_out : host_ad;
  assign inta_line = inta_n_oe ? inta_n_out : 1'b1;
  quad_uart_pci DUT (.clock(clock), .rst_n(rst_n), .ad_in(ad_bus), .ad_out(ad_out),
    .ad_oe(ad_oe), .cbe_n(cbe_n), .frame_n(frame_n), .irdy_n(irdy_n), .trdy_n(trdy_n),
    .devsel_n(devsel_n), .stop_n(stop_n), .target_oe(target_oe), .par_out(par_out),
    .par_oe(par_oe), .perr_n(perr_n), .serr_n_out(serr_n_out), .serr_n_oe(serr_n_oe),
    .inta_n_out(inta_n_out), .inta_n_oe(inta_n_oe), .serial_out(serial_out),
    .serial_in(serial_out), .request_send_n(request_send_n),
    .terminal_ready_n(terminal_ready_n), .clear_send_n(clear_send_n),
    .set_ready_n(set_ready_n), .carrier_detect_n(carrier_detect_n),
    .ring_indicate_n(ring_indicate_n), .dir_out(dir_out));
  pci_host_model host (.clock(clock), .frame_n(frame_n), .irdy_n(irdy_n), .cbe_n(cbe_n),
    .host_ad(host_ad), .ad_bus(ad_bus), .trdy_n(trdy_n), .stop_n(stop_n),
    .par_out(par_out), .par_oe(par_oe));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  function automatic logic [11:0] ra(input logic [1:0] ch, input logic [3:0] r);
    return {4'h0, ch, r, 2'b00};
  endfunction
  task automatic wr(input logic [11:0] off, input logic [31:0] d);
    host.access(`CMD_MEM_WR, off, d, 4'h0, rdata, res, pok);
    check(res, 2'h0, "write not taken");
  endtask
  task automatic rd(input logic [11:0] off);
    host.access(`CMD_MEM_RD, off, 32'h0000_0000, 4'h0, rdata, res, pok);
    check(res, 2'h0, "read not taken");
    check(pok, 1'b1, "read parity");
  endtask
  task automatic t_reset();
    check(serial_out, 4'hF, "idle transmit");
    check({request_send_n, terminal_ready_n}, 8'hFF, "modem outputs");
    check({dir_out, inta_line, perr_n, serr_n_oe}, 7'h06, "quiet outputs");
    check({trdy_n, devsel_n, stop_n, target_oe, ad_oe, par_oe}, 6'h38, "target idle");
    rd(ra(2'h0, `REG_FEATURE_CONTROL_REG));
    check(rdata[7:0], 8'h00, "feature reset");
    rd(ra(2'h2, `REG_DIV));
    check(rdata[15:0], `DIV_RESET, "divisor reset");
    rd(ra(2'h3, `REG_TRIG));
    check(rdata[6:0], `TRIG_RX_RESET, "trigger reset");
  endtask
  task automatic t_modem();
    for (int ch = 0; ch < 4; ch++) begin
      wr(ra(2'(ch), `REG_MCR), 32'h1);
      check({request_send_n[ch], terminal_ready_n[ch]}, 2'h2, "ready only");
      wr(ra(2'(ch), `REG_MCR), 32'h2);
      check({request_send_n[ch], terminal_ready_n[ch]}, 2'h1, "send only");
      wr(ra(2'(ch), `REG_MCR), 32'h0);
    end
    @(negedge clock);
    clear_send_n = 4'hE;
    set_ready_n = 4'hD;
    carrier_detect_n = 4'hB;
    ring_indicate_n = 4'h7;
    repeat (4) @(negedge clock);
    for (int ch = 0; ch < 4; ch++) begin
      rd(ra(2'(ch), `REG_MSR));
      check(rdata[3:0], 4'h1 << ch, "modem status");
    end
  endtask
  task automatic t_ignore();
    host.access(4'h2, ra(2'h0, `REG_MCR), 32'h0, 4'h0, rdata, res, pok);
    check(res, 2'h2, "other command claimed");
    host.access(`CMD_MEM_WR, ra(2'h0, `REG_MCR), 32'h3, 4'hF, rdata, res, pok);
    check(request_send_n, 4'hF, "disabled lane written");
  endtask
  task automatic t_loop(input logic [1:0] ch, input logic [7:0] fc, input logic [7:0] b);
    int bit_t;
    bit_t = fc[6] ? 16 : 32;
    wr(ra(ch, `REG_FEATURE_CONTROL_REG), {24'h000000, fc});
    wr(ra(ch, `REG_IER), 32'h1);
    wr(ra(ch, `REG_TADLY), 32'h1);
    wr(ra(ch, `REG_DATA), {24'h000000, b});
    repeat (4) @(negedge clock);
    check(dir_out[ch], 1'b1, "direction low while sending");
    repeat (bit_t * 11) @(negedge clock);
    check(serial_out[ch], !fc[5], "transmit rest level");
    check(inta_line, 1'b0, "no receive interrupt");
    rd(12'h100);
    check(rdata[ch], 1'b1, "source bit");
    rd(ra(ch, `REG_DATA));
    check(rdata[7:0], b, "looped byte");
    check(inta_line, 1'b1, "interrupt stuck");
    check(dir_out[ch], 1'b0, "direction held too long");
  endtask
  task automatic t_timer();
    wr(12'h104, 32'h0000_0020);
    wr(12'h108, 32'h0000_0001);
    repeat (80) @(negedge clock);
    check(inta_line, 1'b0, "no timer interrupt");
    rd(12'h100);
    check(rdata[4], 1'b1, "timer source");
    wr(12'h108, 32'h0000_0002);
    rd(12'h100);
    check(rdata[4], 1'b0, "timer clear");
  endtask
  task automatic t_fill();
    int acc;
    logic seen;
    acc = 0;
    seen = 1'b0;
    for (int i = 0; i < 80 && !seen; i++) begin
      host.access(`CMD_MEM_WR, ra(2'h3, `REG_DATA), 32'(i), 4'h0, rdata, res, pok);
      if (res == 2'h1) seen = 1'b1;
      if (res == 2'h0) acc++;
    end
    check(seen, 1'b1, "full buffer accepted");
    check(acc >= 64, 1'b1, "buffer too small");
  endtask
  initial begin
    rst_n = 1'b0;
    clear_send_n = 4'hF;
    set_ready_n = 4'hF;
    carrier_detect_n = 4'hF;
    ring_indicate_n = 4'hF;
    repeat (10) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
    t_reset();
    t_modem();
    t_ignore();
    t_loop(2'h0, 8'h00, 8'hA5);
    t_loop(2'h1, 8'h60, 8'h3C);
    t_timer();
    t_fill();
    conclude();
  end
endmodule // quad_pci_uart_pin_interface_test
